/* assf_status_flags.sv */
`timescale 1ns/100ps
// Overview of operation
// - reading a slot's result register clears that slot's ready bit.
// - each limit summary clears when all set bits of its half of the limit status are written one.
// - sign change summary clears when all set sign change bits written one.
// - writing one clears an end-of-scan flag; writes never set it.
// - all flags but the two active bits stay set until cleared.
// - first active bit covers sequential, lockstep scans, or converter A.
// - second active bit only for converter B in independent parallel mode.
// - while active, the covered converter ignores sync pulses and starts.
// - first done flag on sequential/lockstep completion or converter A.
// - second done flag only on converter B completion, independent parallel.
// - in looping scans the done flag sets at every iteration.
// - sign change summary sets at the conversion, not scan end.
// - each summary interrupt asserts the cycle after flag and enable are both set.
// - floor check enabled for nonzero floor; below floor sets summary.
// - ceiling check enabled unless disabled code; above sets summary.
// - a slot's ready bit sets when its result is stored.
// - a debug read of a result may clear that slot's ready bit.
module assf_status_flags
    import assf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clockEnable,
    input  wire logic [2:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdData,
    input  wire logic        startA,
    input  wire logic        startB,
    input  wire logic        iterDoneA,
    input  wire logic        iterDoneB,
    input  wire logic        scanStopA,
    input  wire logic        scanStopB,
    input  wire assf_conv_t  conv,
    input  wire logic        resultRead,
    input  wire logic [2:0]  resultReadSlot,
    input  wire logic        debugSession,
    input  wire logic        limitStatusWrite,
    input  wire logic [15:0] limitStatusBits,
    input  wire logic        signStatusWrite,
    input  wire logic [7:0]  signStatusBits,
    output logic             convStartA,
    output logic             convStartB,
    output logic      [7:0]  belowFloorSet,
    output logic      [7:0]  aboveCeilingSet,
    output logic             signChangeIrq,
    output logic             belowFloorIrq,
    output logic             aboveCeilingIrq,
    output logic             irq
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assf_status_t  status_reg;
    assf_control_t control_reg;
    logic [4:0]    evtStatus_reg;
    logic [4:0]    evtMask_reg;
    logic          limitWritePend_reg;
    logic          signWritePend_reg;

    logic          independent;
    logic          acceptA;
    logic          acceptB;
    logic          doneAEvt;
    logic          doneBEvt;
    logic          floorHit;
    logic          ceilingHit;
    logic          signHit;
    logic [7:0]    slotOneHot;
    logic [7:0]    readClear;
    logic [4:0]    evtNow;
    logic          wrStatus;

    assign independent = control_reg.parallelMode
                       & ~control_reg.lockstepParallelSelect;
    assign wrStatus    = regWrite & (regAddr == OFS_SCAN_STATUS);

    assign acceptA = startA & ~status_reg.scanActiveA;
    assign acceptB = startB & independent & ~status_reg.scanActiveB;

    assign doneAEvt = iterDoneA & status_reg.scanActiveA;
    assign doneBEvt = iterDoneB & independent & status_reg.scanActiveB;

    assign slotOneHot = 8'h01 << conv.slot;

    assign floorHit = conv.done & (conv.floorValue != FLOOR_OFF_CODE)
                    & ($signed(conv.raw) < $signed(conv.floorValue));
    assign ceilingHit = conv.done & (conv.ceilingValue != CEILING_OFF_CODE)
                      & ($signed(conv.raw) > $signed(conv.ceilingValue));
    assign signHit = conv.done & conv.signChange;

    assign readClear = (resultRead
                        & (~debugSession | control_reg.debugReadClears))
                     ? (8'h01 << resultReadSlot) : 8'h00;

    assign evtNow = {doneBEvt, doneAEvt, signHit, floorHit, ceilingHit};

    // ------------------------------------------------------------
    // scan activity
    // ------------------------------------------------------------
    // first converter activity
    always_ff @(posedge clock)
    begin
        if (rst)
            status_reg.scanActiveA <= 1'b0;
        else if (clockEnable)
        begin
            if (acceptA)
                status_reg.scanActiveA <= 1'b1;
            else if (scanStopA | (iterDoneA & ~control_reg.loopMode))
                status_reg.scanActiveA <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            status_reg.scanActiveB <= 1'b0;
        else if (clockEnable)
        begin
            if (!independent)
                status_reg.scanActiveB <= 1'b0;
            else if (acceptB)
                status_reg.scanActiveB <= 1'b1;
            else if (scanStopB | (iterDoneB & ~control_reg.loopMode))
                status_reg.scanActiveB <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            convStartA <= 1'b0;
            convStartB <= 1'b0;
        end
        else if (clockEnable)
        begin
            convStartA <= acceptA;
            convStartB <= acceptB;
        end
    end

    // ------------------------------------------------------------
    // end of scan flags
    // ------------------------------------------------------------
    // set beats a same-cycle write-one clear so no completion is lost
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status_reg.scanDoneAFlag <= 1'b0;
            status_reg.scanDoneBFlag <= 1'b0;
        end
        else if (clockEnable)
        begin
            if (doneAEvt)
                status_reg.scanDoneAFlag <= 1'b1;
            else if (wrStatus & regWrData[BIT_DONE_A])
                status_reg.scanDoneAFlag <= 1'b0;
            if (doneBEvt)
                status_reg.scanDoneBFlag <= 1'b1;
            else if (wrStatus & regWrData[BIT_DONE_B])
                status_reg.scanDoneBFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // summary flags
    // ------------------------------------------------------------
    // detailed bits may still read zero as an event lands, so look later
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            limitWritePend_reg <= 1'b0;
            signWritePend_reg  <= 1'b0;
        end
        else if (clockEnable)
        begin
            limitWritePend_reg <= limitStatusWrite;
            signWritePend_reg  <= signStatusWrite;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status_reg.signChangeSummaryFlag   <= 1'b0;
            status_reg.belowFloorSummaryFlag   <= 1'b0;
            status_reg.aboveCeilingSummaryFlag <= 1'b0;
        end
        else if (clockEnable)
        begin
            if (signHit)
                status_reg.signChangeSummaryFlag <= 1'b1;
            else if (signWritePend_reg & (signStatusBits == 8'h00))
                status_reg.signChangeSummaryFlag <= 1'b0;
            if (floorHit)
                status_reg.belowFloorSummaryFlag <= 1'b1;
            else if (limitWritePend_reg & (limitStatusBits[7:0] == 8'h00))
                status_reg.belowFloorSummaryFlag <= 1'b0;
            if (ceilingHit)
                status_reg.aboveCeilingSummaryFlag <= 1'b1;
            else if (limitWritePend_reg & (limitStatusBits[15:8] == 8'h00))
                status_reg.aboveCeilingSummaryFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            belowFloorSet   <= 8'h00;
            aboveCeilingSet <= 8'h00;
        end
        else if (clockEnable)
        begin
            belowFloorSet   <= floorHit ? slotOneHot : 8'h00;
            aboveCeilingSet <= ceilingHit ? slotOneHot : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // ready bits
    // ------------------------------------------------------------
    // set on store, set wins
    always_ff @(posedge clock)
    begin
        if (rst)
            status_reg.slotResultReady <= 8'h00;
        else if (clockEnable)
            status_reg.slotResultReady <=
                (status_reg.slotResultReady & ~readClear)
                | (conv.done ? slotOneHot : 8'h00);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            status_reg.reserved <= 1'b0;
        else if (clockEnable)
            status_reg.reserved <= 1'b0;
    end

    // ------------------------------------------------------------
    // control, event and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            control_reg <= CONTROL_RESET;
        else if (clockEnable & regWrite & (regAddr == OFS_CONTROL))
            control_reg <= regWrData[6:0];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            evtMask_reg <= EVT_RESET;
        else if (clockEnable & regWrite & (regAddr == OFS_EVT_MASK))
            evtMask_reg <= regWrData[4:0];
    end

    // read clears, a new event in the same cycle survives
    always_ff @(posedge clock)
    begin
        if (rst)
            evtStatus_reg <= EVT_RESET;
        else if (clockEnable)
        begin
            if (regRead & (regAddr == OFS_EVT_STATUS))
                evtStatus_reg <= evtNow;
            else
                evtStatus_reg <= evtStatus_reg | evtNow;
        end
    end

    // ------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------
    // outputs lag the flags by one cycle to stay flop driven
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            signChangeIrq   <= 1'b0;
            belowFloorIrq   <= 1'b0;
            aboveCeilingIrq <= 1'b0;
            irq             <= 1'b0;
        end
        else if (clockEnable)
        begin
            signChangeIrq   <= status_reg.signChangeSummaryFlag
                             & control_reg.signChangeIrqEnable;
            belowFloorIrq   <= status_reg.belowFloorSummaryFlag
                             & control_reg.belowFloorIrqEnable;
            aboveCeilingIrq <= status_reg.aboveCeilingSummaryFlag
                             & control_reg.aboveCeilingIrqEnable;
            irq             <= |(evtStatus_reg & evtMask_reg);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            regRdData <= 16'h0000;
        else if (clockEnable)
        begin
            regRdData <= 16'h0000;
            if (regRead)
            begin
                case (regAddr)
                    OFS_SCAN_STATUS: regRdData <= status_reg;
                    OFS_CONTROL:     regRdData <= {9'h000, control_reg};
                    OFS_EVT_STATUS:  regRdData <= {11'h000, evtStatus_reg};
                    OFS_EVT_MASK:    regRdData <= {11'h000, evtMask_reg};
                    default:         regRdData <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ready_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & resultRead & ~debugSession & ~conv.done
        |=> !status_reg.slotResultReady[$past(resultReadSlot)])
        else $error("ready bit survived its result read");
    floor_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        status_reg.belowFloorSummaryFlag & !limitWritePend_reg & clockEnable
        |=> status_reg.belowFloorSummaryFlag)
        else $error("floor summary cleared without status write");
    sign_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & signWritePend_reg & (signStatusBits == 8'h00)
        & !signHit |=> !status_reg.signChangeSummaryFlag)
        else $error("sign summary not cleared");
    done_wclear_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & wrStatus & regWrData[BIT_DONE_A] & !doneAEvt
        |=> !status_reg.scanDoneAFlag)
        else $error("done flag not cleared by write one");
    done_sticky_a: assert property (
        @(posedge clock) disable iff (rst)
        status_reg.scanDoneBFlag & !(wrStatus & regWrData[BIT_DONE_B])
        |=> status_reg.scanDoneBFlag)
        else $error("done flag dropped without clear");
    busy_ignore_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & status_reg.scanActiveA & startA |=> !convStartA)
        else $error("start accepted while busy");
    b_only_indep_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & !independent |=> !status_reg.scanActiveB)
        else $error("second active bit outside independent mode");
    done_a_set_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & doneAEvt |=> status_reg.scanDoneAFlag)
        else $error("first done flag not set");
    ceil_set_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & ceilingHit
        |=> status_reg.aboveCeilingSummaryFlag ##0 aboveCeilingSet != 8'h00)
        else $error("ceiling event not latched");
    irq_gate_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & !control_reg.belowFloorIrqEnable |=> !belowFloorIrq)
        else $error("floor irq without enable");
    ready_set_a: assert property (
        @(posedge clock) disable iff (rst)
        clockEnable & conv.done
        |=> status_reg.slotResultReady[$past(conv.slot)])
        else $error("ready bit not set on store");

endmodule

/* assf_pkg.sv */
package assf_pkg;

    // ------------------------------------------------------------
    // register map (word addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_SCAN_STATUS = 3'h0;
    localparam logic [2:0] OFS_CONTROL     = 3'h1;
    localparam logic [2:0] OFS_EVT_STATUS  = 3'h2;
    localparam logic [2:0] OFS_EVT_MASK    = 3'h3;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int BIT_DONE_B = 12;
    localparam int BIT_DONE_A = 11;
    localparam int NUM_SLOTS  = 8;
    localparam int NUM_EVTS   = 5;

    localparam logic [15:0] FLOOR_OFF_CODE   = 16'h0000;
    localparam logic [15:0] CEILING_OFF_CODE = 16'h7ff8;

    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam logic [6:0]  CONTROL_RESET = 7'h40;
    localparam logic [4:0]  EVT_RESET     = 5'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       scanActiveA;
        logic       scanActiveB;
        logic       reserved;
        logic       scanDoneBFlag;
        logic       scanDoneAFlag;
        logic       signChangeSummaryFlag;
        logic       belowFloorSummaryFlag;
        logic       aboveCeilingSummaryFlag;
        logic [7:0] slotResultReady;
    } assf_status_t;

    typedef struct packed {
        logic debugReadClears;
        logic parallelMode;
        logic lockstepParallelSelect;
        logic loopMode;
        logic signChangeIrqEnable;
        logic belowFloorIrqEnable;
        logic aboveCeilingIrqEnable;
    } assf_control_t;

    typedef struct packed {
        logic        done;
        logic [2:0]  slot;
        logic [15:0] raw;
        logic [15:0] floorValue;
        logic [15:0] ceilingValue;
        logic        signChange;
    } assf_conv_t;

endpackage

/* assf_status_flags_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) \
        begin \
            nFail++; \
            $display("mismatch %s exp %h got %h", nm, ex, got); \
        end \
    end

module assf_status_flags_tb_top
    import assf_pkg::*;
();
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    localparam logic [9:0] P_STA = 10'h001;
    localparam logic [9:0] P_STB = 10'h002;
    localparam logic [9:0] P_ITA = 10'h004;
    localparam logic [9:0] P_ITB = 10'h008;
    localparam logic [9:0] P_SPA = 10'h010;
    localparam logic [9:0] P_SPB = 10'h020;
    localparam logic [9:0] P_CNV = 10'h040;
    localparam logic [9:0] P_RRD = 10'h080;
    localparam logic [9:0] P_LWR = 10'h100;
    localparam logic [9:0] P_SWR = 10'h200;

    logic        clock;
    logic        rst;
    logic        clockEnable;
    logic [2:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrite;
    logic        regRead;
    logic [15:0] regRdData;
    logic [9:0]  pv;
    logic [2:0]  convSlot;
    logic [15:0] convRaw;
    logic [15:0] convFloor;
    logic [15:0] convCeil;
    logic        convSign;
    assf_conv_t  convBus;
    logic [2:0]  resultReadSlot;
    logic        debugSession;
    logic [15:0] limitStatusBits;
    logic [7:0]  signStatusBits;
    logic        convStartA;
    logic        convStartB;
    logic [7:0]  belowFloorSet;
    logic [7:0]  aboveCeilingSet;
    logic        signChangeIrq;
    logic        belowFloorIrq;
    logic        aboveCeilingIrq;
    logic        irq;
    logic        rdSeen;
    logic [15:0] expNow;
    logic [15:0] expQ[$];
    logic [15:0] lfsr;
    logic [2:0]  s;
    int          nFail;
    int          compares;

    assign convBus = {pv[6], convSlot, convRaw, convFloor, convCeil,
                      convSign};

    assf_status_flags assf_status_flags_i (
        .clock           (clock),
        .rst             (rst),
        .clockEnable     (clockEnable),
        .regAddr         (regAddr),
        .regWrData       (regWrData),
        .regWrite        (regWrite),
        .regRead         (regRead),
        .regRdData       (regRdData),
        .startA          (pv[0]),
        .startB          (pv[1]),
        .iterDoneA       (pv[2]),
        .iterDoneB       (pv[3]),
        .scanStopA       (pv[4]),
        .scanStopB       (pv[5]),
        .conv            (convBus),
        .resultRead      (pv[7]),
        .resultReadSlot  (resultReadSlot),
        .debugSession    (debugSession),
        .limitStatusWrite(pv[8]),
        .limitStatusBits (limitStatusBits),
        .signStatusWrite (pv[9]),
        .signStatusBits  (signStatusBits),
        .convStartA      (convStartA),
        .convStartB      (convStartB),
        .belowFloorSet   (belowFloorSet),
        .aboveCeilingSet (aboveCeilingSet),
        .signChangeIrq   (signChangeIrq),
        .belowFloorIrq   (belowFloorIrq),
        .aboveCeilingIrq (aboveCeilingIrq),
        .irq             (irq)
    );

    always #10 clock = ~clock;

    // read data stand only in the cycle after the strobe
    always @(posedge clock) rdSeen <= regRead;
    always @(negedge clock)
    begin
        if (rdSeen === 1'b1)
        begin
            expNow = expQ.pop_front();
            `CHK("regRdData", expNow, regRdData)
        end
    end

    // ------------------------------------------------------------
    // bus and pulse tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsrNext(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask

    // ends just after the sampling edge so registered results settled
    task automatic pulse(input logic [9:0] m);
        @(posedge clock);
        pv <= m;
        @(posedge clock);
        pv <= '0;
        #1;
    endtask

    task automatic doConv(input logic [2:0] sl, input logic [15:0] r,
                          input logic [15:0] f, input logic [15:0] c,
                          input logic sg);
        @(posedge clock);
        convSlot  <= sl;
        convRaw   <= r;
        convFloor <= f;
        convCeil  <= c;
        convSign  <= sg;
        pv        <= P_CNV;
        @(posedge clock);
        pv <= '0;
        #1;
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        clockEnable = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        pv = '0;
        {convSlot, convRaw, convFloor, convCeil, convSign} = '0;
        resultReadSlot = '0;
        debugSession = 1'b0;
        limitStatusBits = '0;
        signStatusBits = '0;
        lfsr = 16'h5d15;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_SCAN_STATUS, 16'h0000);
        rd(OFS_CONTROL, 16'h0040);
        rd(OFS_EVT_STATUS, 16'h0000);
        rd(OFS_EVT_MASK, 16'h0000);
        wr(3'h5, 16'hffff);
        rd(3'h5, 16'h0000);
        $display("test reset done");
        pulse(P_STA);
        `CHK("convStartA", 1'b1, convStartA)
        rd(OFS_SCAN_STATUS, 16'h8000);
        pulse(P_STA | P_STB);
        `CHK("convStartA", 1'b0, convStartA)
        `CHK("convStartB", 1'b0, convStartB)
        pulse(P_ITA);
        rd(OFS_SCAN_STATUS, 16'h0800);
        pulse(P_STA);
        rd(OFS_SCAN_STATUS, 16'h8800);
        pulse(P_ITA);
        rd(OFS_EVT_STATUS, 16'h0008);
        rd(OFS_EVT_STATUS, 16'h0000);
        wr(OFS_SCAN_STATUS, 16'hffff);
        rd(OFS_SCAN_STATUS, 16'h0000);
        $display("test sequential done");
        wr(OFS_CONTROL, 16'h0060);
        pulse(P_STA | P_STB);
        `CHK("convStartB", 1'b1, convStartB)
        rd(OFS_SCAN_STATUS, 16'hc000);
        pulse(P_ITB);
        rd(OFS_SCAN_STATUS, 16'h9000);
        pulse(P_ITA);
        rd(OFS_SCAN_STATUS, 16'h1800);
        pulse(P_STB);
        pulse(P_SPB);
        rd(OFS_SCAN_STATUS, 16'h1800);
        wr(OFS_SCAN_STATUS, 16'h1000);
        rd(OFS_SCAN_STATUS, 16'h0800);
        wr(OFS_SCAN_STATUS, 16'h0800);
        wr(OFS_CONTROL, 16'h0070);
        pulse(P_STB);
        `CHK("convStartB", 1'b0, convStartB)
        rd(OFS_SCAN_STATUS, 16'h0000);
        $display("test parallel done");
        wr(OFS_CONTROL, 16'h0048);
        pulse(P_STA);
        pulse(P_ITA);
        wr(OFS_SCAN_STATUS, 16'h0800);
        pulse(P_ITA);
        rd(OFS_SCAN_STATUS, 16'h8800);
        pulse(P_SPA);
        rd(OFS_SCAN_STATUS, 16'h0800);
        wr(OFS_SCAN_STATUS, 16'h0800);
        $display("test loop done");
        wr(OFS_CONTROL, 16'h0047);
        wr(OFS_EVT_MASK, 16'h0002);
        s = lfsr[2:0];
        doConv(s, {8'h00, lfsr[15:8]}, 16'h0100, CEILING_OFF_CODE, 1'b0);
        `CHK("belowFloorSet", 8'h01 << s, belowFloorSet)
        `CHK("aboveCeilingSet", 8'h00, aboveCeilingSet)
        @(posedge clock);
        #1;
        `CHK("belowFloorIrq", 1'b1, belowFloorIrq)
        `CHK("irq", 1'b1, irq)
        rd(OFS_SCAN_STATUS, 16'h0200 | (16'h0001 << s));
        resultReadSlot <= s;
        pulse(P_RRD);
        rd(OFS_SCAN_STATUS, 16'h0200);
        limitStatusBits <= 16'h0001;
        pulse(P_LWR);
        settle();
        rd(OFS_SCAN_STATUS, 16'h0200);
        limitStatusBits <= 16'h0000;
        pulse(P_LWR);
        settle();
        rd(OFS_SCAN_STATUS, 16'h0000);
        `CHK("belowFloorIrq", 1'b0, belowFloorIrq)
        // done events of the parallel and loop tests are still pending
        rd(OFS_EVT_STATUS, 16'h001a);
        settle();
        `CHK("irq", 1'b0, irq)
        lfsr = lfsrNext(lfsr);
        s = lfsr[2:0];
        doConv(s, 16'h8000, FLOOR_OFF_CODE, CEILING_OFF_CODE, 1'b0);
        `CHK("belowFloorSet", 8'h00, belowFloorSet)
        rd(OFS_SCAN_STATUS, 16'h0001 << s);
        debugSession <= 1'b1;
        resultReadSlot <= s;
        pulse(P_RRD);
        debugSession <= 1'b0;
        rd(OFS_SCAN_STATUS, 16'h0000);
        lfsr = lfsrNext(lfsr);
        s = lfsr[2:0];
        doConv(s, 16'h2000, FLOOR_OFF_CODE, 16'h1000, 1'b1);
        `CHK("aboveCeilingSet", 8'h01 << s, aboveCeilingSet)
        @(posedge clock);
        #1;
        `CHK("aboveCeilingIrq", 1'b1, aboveCeilingIrq)
        `CHK("signChangeIrq", 1'b1, signChangeIrq)
        `CHK("irq", 1'b0, irq)
        rd(OFS_SCAN_STATUS, 16'h0500 | (16'h0001 << s));
        pulse(P_LWR | P_SWR);
        settle();
        rd(OFS_SCAN_STATUS, 16'h0001 << s);
        rd(OFS_EVT_STATUS, 16'h0005);
        settle();
        // start and conversion must both be ignored while disabled
        clockEnable <= 1'b0;
        pulse(P_STA | P_CNV);
        `CHK("convStartA", 1'b0, convStartA)
        clockEnable <= 1'b1;
        rd(OFS_SCAN_STATUS, 16'h0020);
        $display("test events done");
        complete_run();
    end

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #200000;
        nFail++;
        complete_run();
    end
endmodule
